//--- core/hcrm_debounce.v
`timescale 1ns/1ps
`include "hcrm_defines.vh"
// accepts a new level after it has held steady for the debounce count
module hcrm_debounce (
	// clock and reset
	input  wire core_clk,
	input  wire rst,
	// synchronised level and filtered level
	input  wire level_in,
	output reg  level_out
);
	reg [15:0] cnt_reg;

	// restart count whenever input matches output, take level when count expires
	always @(posedge core_clk) begin
		if (rst) begin
			cnt_reg   <= 16'h0000;
			level_out <= 1'b0;
		end else if (level_in == level_out) begin
			cnt_reg <= 16'h0000;
		end else if ({16'h0000, cnt_reg} == (`HCRM_DEB_CYC - 1)) begin
			cnt_reg   <= 16'h0000;
			level_out <= level_in;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end
endmodule

//--- core/hcrm_sync.v
`timescale 1ns/1ps
// two-flop synchroniser for one pin
module hcrm_sync (
	// clock and reset
	input  wire core_clk,
	input  wire rst,
	// pin and result
	input  wire pin_in,
	output reg  sync_out
);
	reg meta_reg;

	// first flop is read only by the second
	always @(posedge core_clk) begin
		if (rst) begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			sync_out <= meta_reg;
		end
	end
endmodule

//--- core/hcrm_top.v
`timescale 1ns/1ps
`include "hcrm_defines.vh"

module hcrm_top (
	// clock and reset
	input  wire        core_clk,
	input  wire        rst,
	// avalon-mm slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// switches and sensors
	input  wire        head_position_switch,
	input  wire        rewinder_cover_switch,
	input  wire        liner_level_sensor_a,
	input  wire        liner_level_sensor_b,
	input  wire        encoder_pulse,
	// outputs
	output reg         head_position_sense,
	output reg         fault_lamp,
	output reg  [1:0]  message_sel,
	output reg         motor_on,
	output reg  [1:0]  motor_speed,
	output reg  [1:0]  liner_stage,
	output reg         irq
);
	// ----------------------------------------------------------------
	// message codes and motor states
	// ----------------------------------------------------------------
	localparam MSG_NONE   = 2'h0;
	localparam MSG_HEAD   = 2'h1;
	localparam MSG_COVER  = 2'h2;
	localparam MSG_FULL   = 2'h3;
	localparam ST_IDLE    = 3'b001;
	localparam ST_RUN     = 3'b010;
	localparam ST_HALT    = 3'b100;

	// ----------------------------------------------------------------
	// input synchronisers and debouncers
	// ----------------------------------------------------------------
	wire [4:0] pin_raw;
	wire [4:0] pin_sync;
	wire [3:0] pin_deb;
	// pins in a fixed order: switches, flap sensors, encoder last
	assign pin_raw = {encoder_pulse, liner_level_sensor_b, liner_level_sensor_a,
		rewinder_cover_switch, head_position_switch};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
			hcrm_sync u_sync (
				.core_clk (core_clk),
				.rst      (rst),
				.pin_in   (pin_raw[gi]),
				.sync_out (pin_sync[gi])
			);
		end
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_deb
			hcrm_debounce u_deb (
				.core_clk  (core_clk),
				.rst       (rst),
				.level_in  (pin_sync[gi]),
				.level_out (pin_deb[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// condition decode
	// ----------------------------------------------------------------
	wire       head_up;
	wire       cover_open;
	wire       sens_a;
	wire       sens_b;
	reg  [1:0] stage_next;
	wire       is_full;

	// switches read closed as 1 once past the debouncers
	assign head_up    = ~pin_deb[0];
	assign cover_open = ~pin_deb[1];
	assign sens_a     = pin_deb[2];
	assign sens_b     = pin_deb[3];

	// stage from the two flap sensors
	always @* begin
		case ({sens_a, sens_b})
			2'b10:   stage_next = `HCRM_STAGE1;
			2'b11:   stage_next = `HCRM_STAGE2;
			2'b01:   stage_next = `HCRM_STAGE3;
			default: stage_next = `HCRM_STAGE_FULL;
		endcase
	end
	assign is_full = (stage_next == `HCRM_STAGE_FULL);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	reg        enable_reg;
	reg [15:0] tmo_reg;
	reg [3:0]  mask_reg;
	reg [3:0]  ev_stat_reg;
	reg        print_pulse_reg;

	wire bus_rd;
	wire bus_wr;
	// a request counts only in its first cycle, while waitrequest is still high
	assign bus_rd = avs_read & avs_waitrequest;
	assign bus_wr = avs_write & avs_waitrequest;

	// control writes; print bit is a self-clearing start pulse
	always @(posedge core_clk) begin
		if (rst) begin
			enable_reg      <= `HCRM_CTRL_RST;
			tmo_reg         <= `HCRM_TMO_RST;
			mask_reg        <= `HCRM_MASK_RST;
			print_pulse_reg <= 1'b0;
		end else begin
			print_pulse_reg <= 1'b0;
			if (bus_wr && avs_address == `HCRM_OFF_CTRL) begin
				enable_reg      <= avs_writedata[`HCRM_CTRL_EN_BIT];
				print_pulse_reg <= avs_writedata[`HCRM_CTRL_PRINT_BIT];
				tmo_reg         <= avs_writedata[`HCRM_CTRL_TMO_LSB +: 16];
			end
			if (bus_wr && avs_address == `HCRM_OFF_IRQ_MASK) begin
				mask_reg <= avs_writedata[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// encoder edge watch and motor state machine
	// ----------------------------------------------------------------
	reg        enc_d_reg;
	reg [15:0] idle_cnt_reg;
	reg [2:0]  state_reg;
	reg [2:0]  state_next;
	reg        wind_done;
	wire       enc_edge;
	wire       blocked;
	wire       enc_timeout;

	// any change of the synchronised encoder level counts as a pulse edge
	assign enc_edge    = pin_sync[4] ^ enc_d_reg;
	assign blocked     = head_up | cover_open | is_full;
	assign enc_timeout = (idle_cnt_reg >= tmo_reg);

	// count clocks since the last encoder edge while running
	always @(posedge core_clk) begin
		if (rst) begin
			enc_d_reg    <= 1'b0;
			idle_cnt_reg <= 16'h0000;
		end else begin
			enc_d_reg <= pin_sync[4];
			if (state_reg != ST_RUN || enc_edge) begin
				idle_cnt_reg <= 16'h0000;
			end else if (!enc_timeout) begin
				idle_cnt_reg <= idle_cnt_reg + 16'h0001;
			end
		end
	end

	// next motor state
	always @* begin
		state_next = state_reg;
		wind_done  = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (print_pulse_reg && enable_reg && !blocked) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (is_full) begin
					state_next = ST_HALT;
				end else if (blocked || !enable_reg) begin
					state_next = ST_IDLE;
				end else if (enc_timeout) begin
					state_next = ST_IDLE;
					wind_done  = 1'b1;
				end
			end
			ST_HALT: begin
				if (!is_full) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// motor state register
	always @(posedge core_clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// motor outputs registered from next state
	always @(posedge core_clk) begin
		if (rst) begin
			motor_on    <= 1'b0;
			motor_speed <= `HCRM_SPEED_STOP;
			liner_stage <= `HCRM_STAGE1;
		end else begin
			liner_stage <= stage_next;
			motor_on    <= (state_next == ST_RUN);
			if (state_next != ST_RUN) begin
				motor_speed <= `HCRM_SPEED_STOP;
			end else begin
				case (stage_next)
					`HCRM_STAGE1: motor_speed <= `HCRM_SPEED_FAST;
					`HCRM_STAGE2: motor_speed <= `HCRM_SPEED_MID;
					`HCRM_STAGE3: motor_speed <= `HCRM_SPEED_SLOW;
					default:      motor_speed <= `HCRM_SPEED_STOP;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// error lamp and message
	// ----------------------------------------------------------------
	reg [27:0] blink_cnt_reg;
	reg        blink_reg;
	wire       any_err;
	wire       blink_wrap;
	assign any_err    = head_up | cover_open | is_full;
	assign blink_wrap = ({4'h0, blink_cnt_reg} == (`HCRM_BLINK_CYC - 1));

	// blink phase restarts lit while no error, so the lamp comes on at once
	always @(posedge core_clk) begin
		if (rst) begin
			blink_cnt_reg <= 28'h0000000;
			blink_reg     <= 1'b1;
		end else if (!any_err) begin
			blink_cnt_reg <= 28'h0000000;
			blink_reg     <= 1'b1;
		end else if (blink_wrap) begin
			blink_cnt_reg <= 28'h0000000;
			blink_reg     <= ~blink_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 28'h0000001;
		end
	end

	// lamp blinks on any error; head wins, then cover, then full
	always @(posedge core_clk) begin
		if (rst) begin
			fault_lamp          <= 1'b0;
			message_sel         <= MSG_NONE;
			head_position_sense <= 1'b0;
		end else begin
			head_position_sense <= head_up;
			fault_lamp          <= any_err & blink_reg;
			if (head_up) begin
				message_sel <= MSG_HEAD;
			end else if (cover_open) begin
				message_sel <= MSG_COVER;
			end else if (is_full) begin
				message_sel <= MSG_FULL;
			end else begin
				message_sel <= MSG_NONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt status: set wins over read-clear
	// ----------------------------------------------------------------
	wire [3:0] ev_set;
	reg  [3:0] cond_d_reg;
	wire [3:0] cond_now;
	wire [3:0] irq_pending;
	// events latch on the rising edge of each error condition
	assign cond_now    = {1'b0, is_full, cover_open, head_up};
	assign ev_set      = (cond_now & ~cond_d_reg) | {wind_done, 3'b000};
	assign irq_pending = ev_stat_reg & mask_reg;

	// sticky events, cleared by a read of the interrupt status register
	always @(posedge core_clk) begin
		if (rst) begin
			cond_d_reg  <= 4'h0;
			ev_stat_reg <= 4'h0;
			irq         <= 1'b0;
		end else begin
			cond_d_reg <= cond_now;
			if (bus_rd && avs_address == `HCRM_OFF_IRQ_STAT) begin
				ev_stat_reg <= ev_set;
			end else begin
				ev_stat_reg <= ev_stat_reg | ev_set;
			end
			irq <= |irq_pending;
		end
	end

	// ----------------------------------------------------------------
	// read mux and bus answer: one wait cycle, then data
	// ----------------------------------------------------------------
	reg  [31:0] rdata_next;
	wire [9:0]  status_word;
	// status fields: motor state, stage, error flags, motor on
	assign status_word = {state_reg, stage_next, is_full, cover_open, head_up, motor_on, 1'b0};

	// word selected by the address of the request
	always @* begin
		case (avs_address)
			`HCRM_OFF_CTRL:     rdata_next = {tmo_reg, 14'h0000, 1'b0, enable_reg};
			`HCRM_OFF_STATUS:   rdata_next = {22'h000000, status_word};
			`HCRM_OFF_IRQ_STAT: rdata_next = {28'h0000000, ev_stat_reg};
			`HCRM_OFF_IRQ_MASK: rdata_next = {28'h0000000, mask_reg};
			default:            rdata_next = 32'h00000000;    // unmapped reads return zero
		endcase
	end

	// waitrequest drops for the one cycle after a request is taken
	always @(posedge core_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			avs_waitrequest <= ~(bus_rd | bus_wr);
			if (bus_rd) begin
				avs_readdata <= rdata_next;
			end
		end
	end
endmodule

//--- include/hcrm_defines.vh
`ifndef HCRM_DEFINES_VH
`define HCRM_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (byte addresses, word aligned)
// ----------------------------------------------------------------
`define HCRM_OFF_CTRL      4'h0
`define HCRM_OFF_STATUS    4'h4
`define HCRM_OFF_IRQ_STAT  4'h8
`define HCRM_OFF_IRQ_MASK  4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HCRM_CTRL_EN_BIT      0
`define HCRM_CTRL_PRINT_BIT   1
`define HCRM_CTRL_TMO_LSB     16
`define HCRM_EV_HEAD_OPEN     0
`define HCRM_EV_COVER_OPEN    1
`define HCRM_EV_FULL          2
`define HCRM_EV_WIND_DONE     3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HCRM_CTRL_RST      1'b0
`define HCRM_TMO_RST       16'h1000
`define HCRM_MASK_RST      4'h0

// ----------------------------------------------------------------
// stage codes and motor speeds
// ----------------------------------------------------------------
`define HCRM_STAGE1        2'h0
`define HCRM_STAGE2        2'h1
`define HCRM_STAGE3        2'h2
`define HCRM_STAGE_FULL    2'h3
`define HCRM_SPEED_STOP    2'h0
`define HCRM_SPEED_SLOW    2'h1
`define HCRM_SPEED_MID     2'h2
`define HCRM_SPEED_FAST    2'h3

// ----------------------------------------------------------------
// timing: debounce 1000 ns at 4 ns clock, blink half period 250 ms
// ----------------------------------------------------------------
`define HCRM_CLK_NS        4
`define HCRM_DEB_NS        1000
`define HCRM_DEB_CYC       ((`HCRM_DEB_NS + `HCRM_CLK_NS - 1) / `HCRM_CLK_NS)
`define HCRM_BLINK_MS      250
`define HCRM_BLINK_CYC     ((`HCRM_BLINK_MS * 1000000) / `HCRM_CLK_NS)

`endif

//--- verification/hcrm_far.sv
`timescale 1ns/1ps
// ----------------
// switches, interrupters, encoder
// ----------------
module hcrm_far (
	// clock and motor state
	input  wire       core_clk,
	input  wire       motor_on,
	// bench settings
	input  wire       head_down,
	input  wire       cover_shut,
	input  wire [1:0] stage,
	input  wire       spin,
	input  wire [2:0] half,
	// pins
	output reg        head_position_switch,
	output reg        rewinder_cover_switch,
	output reg        liner_level_sensor_a,
	output reg        liner_level_sensor_b,
	output reg        encoder_pulse
);
	reg [2:0] cnt_reg;
	initial begin
		encoder_pulse = 1'b0;
		cnt_reg = 3'h0;
	end
	// switch and flap levels
	always @* begin
		head_position_switch = head_down;
		rewinder_cover_switch = cover_shut;
		liner_level_sensor_a = (stage < 2'h2);
		liner_level_sensor_b = (stage == 2'h1) || (stage == 2'h2);
	end
	// blade pulses only while the motor turns freely
	always @(posedge core_clk) begin
		if (motor_on && spin) begin
			cnt_reg <= cnt_reg + 3'h1;
			if (cnt_reg >= half) begin
				cnt_reg <= 3'h0;
				encoder_pulse <= ~encoder_pulse;
			end
		end
	end
endmodule

//--- verification/hcrm_top_properties.sv
`timescale 1ns/1ps
// ----------------
// port checker
// ----------------
module hcrm_props (
	// clock and reset
	input  wire       core_clk,
	input  wire       rst,
	// bus handshake
	input  wire       avs_read,
	input  wire       avs_write,
	input  wire       avs_waitrequest,
	// status outputs
	input  wire       head_position_sense,
	input  wire       fault_lamp,
	input  wire [1:0] message_sel,
	input  wire       motor_on,
	input  wire [1:0] motor_speed,
	input  wire [1:0] liner_stage
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// bus answer and release
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	wait_drop_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	// head up effects
	head_msg_a: assert property (head_position_sense |-> ##[0:2] message_sel == 2'h1)
		else $error("head open message missing");
	head_off_a: assert property (head_position_sense |-> ##[0:2] !motor_on)
		else $error("motor runs with head up");
	// full spool effects
	full_stop_a: assert property (liner_stage == 2'h3 |-> ##[0:2] !motor_on)
		else $error("motor runs when full");
	full_msg_a: assert property (liner_stage == 2'h3 |-> ##[0:2] message_sel != 2'h0)
		else $error("full message missing");
	// speed by stage
	speed_fast_a: assert property (motor_on && liner_stage == 2'h0 |-> ##[0:2]
		(motor_speed == 2'h3 || !motor_on)) else $error("stage one not fast");
	speed_slow_a: assert property (motor_on && liner_stage == 2'h2 |-> ##[0:2]
		(motor_speed == 2'h1 || !motor_on)) else $error("stage three not slow");
	// lamp dark without error, lit on a new error
	lamp_idle_a: assert property ((message_sel == 2'h0) [*3] |-> !fault_lamp)
		else $error("lamp lit without error");
	lamp_on_a: assert property ($rose(message_sel != 2'h0) |-> fault_lamp)
		else $error("lamp dark on new error");
	run_c: cover property ($rose(motor_on));
	full_c: cover property (liner_stage == 2'h3);
	head_c: cover property ($rose(head_position_sense));
endmodule
bind hcrm_top hcrm_props u_hcrm_props (.core_clk(core_clk), .rst(rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.head_position_sense(head_position_sense), .fault_lamp(fault_lamp),
	.message_sel(message_sel), .motor_on(motor_on), .motor_speed(motor_speed),
	.liner_stage(liner_stage));

//--- verification/test_hcrm_top.sv
`timescale 1ns/1ps
// ----------------
// testbench
// ----------------
module test_hcrm_top;
	reg core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	reg [3:0] avs_address = 4'h0;
	reg [31:0] avs_writedata = 32'h0, seed = 32'd18667, e, m;
	reg head_down = 1'b1, cover_shut = 1'b1, spin = 1'b0;
	reg [1:0] stage = 2'h0;
	reg [2:0] half = 3'h1;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, hsw, csw, lsa, lsb, enc, head_position_sense, fault_lamp, motor_on, irq;
	wire [1:0] message_sel, motor_speed, liner_stage;
	int fail_count = 0, samples_checked = 0, s;
	logic [31:0] exp_q[$], msk_q[$];
	always #2 core_clk = ~core_clk;
	hcrm_top u_hcrm_top (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.head_position_switch(hsw), .rewinder_cover_switch(csw), .liner_level_sensor_a(lsa),
		.liner_level_sensor_b(lsb), .encoder_pulse(enc), .head_position_sense(head_position_sense),
		.fault_lamp(fault_lamp), .message_sel(message_sel), .motor_on(motor_on),
		.motor_speed(motor_speed), .liner_stage(liner_stage), .irq(irq));
	hcrm_far u_hcrm_far (.core_clk(core_clk), .motor_on(motor_on), .head_down(head_down),
		.cover_shut(cover_shut), .stage(stage), .spin(spin), .half(half),
		.head_position_switch(hsw), .rewinder_cover_switch(csw), .liner_level_sensor_a(lsa),
		.liner_level_sensor_b(lsb), .encoder_pulse(enc));
	// xorshift source
	function automatic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// one bus cycle, held until waitrequest is low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] k);
		exp_q.push_back(x);
		msk_q.push_back(k);
		bus(1'b0, a, 32'h0);
	endtask
	task chk(input logic [1:0] got, input logic [1:0] x);
		samples_checked++;
		if (got !== x) begin
			$display("Error %0t: port %h want %h", $time, got, x);
			fail_count++;
		end
	endtask
	task pause();
		repeat (300) @(posedge core_clk);
	endtask
	// read data compared against the oldest note
	always @(posedge core_clk) begin
		if (avs_read && !avs_waitrequest) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			samples_checked++;
			if ((avs_readdata & m) !== (e & m)) begin
				$display("Error %0t: read %h want %h", $time, avs_readdata, e);
				fail_count++;
			end
		end
	end
	task give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// watchdog
	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rd(4'h0, 32'h10000000, 32'hffffffff);
		rd(4'hc, 32'h0, 32'hffffffff);
		rd(4'h2, 32'h0, 32'hffffffff);
		bus(1'b1, 4'h0, 32'h00140001);
		rd(4'h0, 32'h00140001, 32'hffffffff);
		bus(1'b1, 4'hc, 32'hf);
		pause();
		rd(4'h8, 32'h0, 32'h0);
		rd(4'h8, 32'h0, 32'hffffffff);
		chk(irq, 1'b0);
		$display("registers done");
		for (s = 0; s < 3; s++) begin
			stage <= s;
			half <= 3'h1 + xs() % 4;
			spin <= 1'b1;
			pause();
			bus(1'b1, 4'h0, 32'h00140003);
			repeat (6) @(posedge core_clk);
			chk(motor_on, 1'b1);
			chk(motor_speed, 3 - s);
			chk(liner_stage, s);
			rd(4'h4, 32'h102 | (s << 5), 32'h3ff);
			spin <= 1'b0;
			repeat (40) @(posedge core_clk);
			chk(motor_on, 1'b0);
			chk(irq, 1'b1);
			rd(4'h8, 32'h8, 32'hffffffff);
		end
		$display("winding done");
		stage <= 2'h0;
		spin <= 1'b1;
		pause();
		bus(1'b1, 4'h0, 32'h00140003);
		stage <= 2'h3;
		pause();
		chk(motor_on, 1'b0);
		chk(liner_stage, 2'h3);
		chk(message_sel, 2'h3);
		chk(fault_lamp, 1'b1);
		rd(4'h4, 32'h270, 32'h3ff);
		rd(4'h8, 32'h4, 32'hffffffff);
		stage <= 2'h0;
		spin <= 1'b0;
		head_down <= 1'b0;
		pause();
		chk(head_position_sense, 1'b1);
		chk(message_sel, 2'h1);
		chk(fault_lamp, 1'b1);
		bus(1'b1, 4'hc, 32'h0);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b0);
		bus(1'b1, 4'hc, 32'hf);
		bus(1'b1, 4'h0, 32'h00140003);
		repeat (6) @(posedge core_clk);
		chk(motor_on, 1'b0);
		chk(irq, 1'b1);
		cover_shut <= 1'b0;
		pause();
		chk(message_sel, 2'h1);
		head_down <= 1'b1;
		pause();
		chk(message_sel, 2'h2);
		chk(fault_lamp, 1'b1);
		rd(4'h8, 32'h3, 32'hffffffff);
		cover_shut <= 1'b1;
		pause();
		chk(message_sel, 2'h0);
		chk(fault_lamp, 1'b0);
		chk(head_position_sense, 1'b0);
		chk(irq, 1'b0);
		$display("errors done");
		give_verdict();
	end
endmodule
